//--- capture_compare_timer16_pkg.sv
// package for the 16-bit capture/compare timer
// assumes a 32-bit classic wishbone master, byte addressed, word aligned
package capture_compare_timer16_pkg;

    // ==========================================
    // register offsets (byte addresses)
    localparam logic [4:0] OFS_MODE_CONTROL = 5'h00;
    localparam logic [4:0] OFS_CAPTURE_COMPARE_CONTROL = 5'h04;
    localparam logic [4:0] OFS_OUTPUT_CONTROL = 5'h08;
    localparam logic [4:0] OFS_PRESCALER_MODE = 5'h0c;
    localparam logic [4:0] OFS_COUNTER = 5'h10;
    localparam logic [4:0] OFS_CC_FIRST = 5'h14;
    localparam logic [4:0] OFS_CC_SECOND = 5'h18;

    // ==========================================
    // field positions
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_OP_LO = 2;
    localparam int CRC_FIRST_CAPTURE = 0;
    localparam int CRC_FIRST_REVERSE_A = 1;
    localparam int CRC_SECOND_CAPTURE = 2;
    localparam int TOC_PIN_EN = 0;
    localparam int TOC_TOGGLE_FIRST = 1;
    localparam int TOC_LEVEL_RESET = 2;
    localparam int TOC_LEVEL_SET = 3;
    localparam int TOC_TOGGLE_SECOND = 4;
    localparam int PRM_CLK_LO = 0;
    localparam int PRM_EDGE_A_LO = 4;
    localparam int PRM_EDGE_B_LO = 6;

    // ==========================================
    // reset values
    localparam logic [2:0] RST_CRC = 3'h0;
    localparam logic [6:0] RST_TOC = 7'h00;
    localparam logic [7:0] RST_PRM = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // ==========================================
    // modes and edge encodings
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_FREE_RUN = 2'b01,
        MODE_CLEAR_ON_EDGE = 2'b10,
        MODE_CLEAR_ON_MATCH = 2'b11
    } op_mode_e;

    localparam logic [1:0] EDGE_FALL = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // ==========================================
    // carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [4:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        op_mode_e mode;
        logic ovf;
        logic [2:0] crc;
        logic [6:0] toc;
        logic [7:0] prm;
        logic [15:0] cnt;
        logic [15:0] cc_first;
        logic [15:0] cc_second;
        logic lvl;
        logic pin;
        logic irq_first;
        logic irq_second;
        logic [2:0] div;
        logic a_s1;
        logic a_s2;
        logic a_s3;
        logic b_s1;
        logic b_s2;
        logic b_s3;
        logic ack;
        logic [31:0] dat;
    } timer_state_s;

endpackage

//--- capture_compare_timer16.sv
// 16-bit up-counter with two capture/compare registers and one toggling output
// assumes a classic wishbone master on clk_i; trigger pins are asynchronous
`timescale 1ns/100ps

module capture_compare_timer16 (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire capture_compare_timer16_pkg::wb_req_s wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // trigger pins
    input wire logic trigger_input_a_i,
    input wire logic trigger_input_b_i,
    // timer output and events
    output logic timer_output_pin_o,
    output logic first_match_capture_irq_o,
    output logic second_match_capture_irq_o
);
    import capture_compare_timer16_pkg::*;

    // ==========================================
    // functions
    function automatic logic edge_hit(input logic [1:0] es, input logic prev, input logic cur);
        logic hit;
        hit = 1'b0;
        case (es)
            EDGE_FALL: hit = prev & ~cur;
            EDGE_RISE: hit = ~prev & cur;
            EDGE_BOTH: hit = prev ^ cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0]) begin
            m[7:0] = d[7:0];
        end
        if (sel[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction

    // ==========================================
    // state
    timer_state_s st_r;
    timer_state_s st_nxt;

    logic run;
    logic tick;
    logic [2:0] div_mask;
    logic [1:0] es_a;
    logic [1:0] es_a_rev;
    logic [1:0] es_b;
    logic a_valid;
    logic a_reverse;
    logic b_valid;
    logic cap_first;
    logic cap_second;
    logic match_first;
    logic match_second;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_data;

    // ==========================================
    // count clock and events
    assign run = st_r.mode != MODE_STOP;
    always_comb begin
        case (st_r.prm[PRM_CLK_LO +: 2])
            2'b00: div_mask = 3'h0;
            2'b01: div_mask = 3'h1;
            2'b10: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end
    // prescaler runs free, so the first tick after start lands anywhere within one count clock
    assign tick = (st_r.div & div_mask) == div_mask;

    assign es_a = st_r.prm[PRM_EDGE_A_LO +: 2];
    assign es_b = st_r.prm[PRM_EDGE_B_LO +: 2];
    assign es_a_rev = {es_a[1], es_a[1] ? es_a[0] : ~es_a[0]};
    // pins are ignored while stopped
    assign a_valid = run & edge_hit(es_a, st_r.a_s3, st_r.a_s2);
    assign a_reverse = run & edge_hit(es_a_rev, st_r.a_s3, st_r.a_s2);
    assign b_valid = run & edge_hit(es_b, st_r.b_s3, st_r.b_s2);

    assign cap_first = st_r.crc[CRC_FIRST_CAPTURE] & (st_r.crc[CRC_FIRST_REVERSE_A] ? a_reverse : b_valid);
    assign cap_second = st_r.crc[CRC_SECOND_CAPTURE] & a_valid;
    assign match_first = run & tick & ~st_r.crc[CRC_FIRST_CAPTURE] & (st_r.cnt == st_r.cc_first);
    assign match_second = run & tick & ~st_r.crc[CRC_SECOND_CAPTURE] & (st_r.cnt == st_r.cc_second);

    // ==========================================
    // bus decode
    assign bus_req = wb_req_i.cyc & wb_req_i.stb;
    // a write takes effect at the edge where the master sees ack
    assign bus_wr = bus_req & st_r.ack & wb_req_i.we;

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_req_i.adr)
            OFS_MODE_CONTROL: begin
                rd_data[MODE_OP_LO +: 2] = st_r.mode;
                rd_data[MODE_OVF_BIT] = st_r.ovf;
            end
            OFS_CAPTURE_COMPARE_CONTROL: rd_data[2:0] = st_r.crc;
            OFS_OUTPUT_CONTROL: rd_data[6:0] = st_r.toc;
            OFS_PRESCALER_MODE: rd_data[7:0] = st_r.prm;
            OFS_COUNTER: rd_data[15:0] = st_r.cnt;
            OFS_CC_FIRST: rd_data[15:0] = st_r.cc_first;
            OFS_CC_SECOND: rd_data[15:0] = st_r.cc_second;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = st_r.div + 3'h1;
        st_nxt.a_s1 = trigger_input_a_i;
        st_nxt.a_s2 = st_r.a_s1;
        st_nxt.a_s3 = st_r.a_s2;
        st_nxt.b_s1 = trigger_input_b_i;
        st_nxt.b_s2 = st_r.b_s1;
        st_nxt.b_s3 = st_r.b_s2;
        st_nxt.irq_first = 1'b0;
        st_nxt.irq_second = 1'b0;
        st_nxt.ack = bus_req & ~st_r.ack;
        if (bus_req & ~st_r.ack) begin
            st_nxt.dat = rd_data;
        end
        // software writes first so that hardware events below win
        if (bus_wr) begin
            case (wb_req_i.adr)
                OFS_MODE_CONTROL: begin
                    if (wb_req_i.sel[0]) begin
                        st_nxt.mode = op_mode_e'(wb_req_i.dat[MODE_OP_LO +: 2]);
                        st_nxt.ovf = wb_req_i.dat[MODE_OVF_BIT];
                    end
                end
                OFS_CAPTURE_COMPARE_CONTROL: begin
                    if (wb_req_i.sel[0]) begin
                        st_nxt.crc = wb_req_i.dat[2:0];
                    end
                end
                OFS_OUTPUT_CONTROL: begin
                    if (wb_req_i.sel[0]) begin
                        st_nxt.toc = wb_req_i.dat[6:0];
                    end
                end
                OFS_PRESCALER_MODE: begin
                    if (wb_req_i.sel[0]) begin
                        st_nxt.prm = wb_req_i.dat[7:0];
                    end
                end
                OFS_CC_FIRST: st_nxt.cc_first = byte_merge(st_r.cc_first, wb_req_i.dat, wb_req_i.sel);
                OFS_CC_SECOND: st_nxt.cc_second = byte_merge(st_r.cc_second, wb_req_i.dat, wb_req_i.sel);
                default: st_nxt.dat = st_nxt.dat;
            endcase
        end
        if (!run) begin
            // stopped counter holds at zero; level bits drive the output
            st_nxt.cnt = RST_WORD;
            case ({st_r.toc[TOC_LEVEL_SET], st_r.toc[TOC_LEVEL_RESET]})
                2'b01: st_nxt.lvl = 1'b0;
                2'b10: st_nxt.lvl = 1'b1;
                default: st_nxt.lvl = st_r.lvl;
            endcase
        end else begin
            // level is carried into the running mode unchanged
            if (tick) begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
                if (st_r.cnt == CNT_MAX) begin
                    st_nxt.ovf = 1'b1;
                end
            end
            if (match_first) begin
                st_nxt.irq_first = 1'b1;
                if (st_r.toc[TOC_TOGGLE_FIRST]) begin
                    st_nxt.lvl = ~st_nxt.lvl;
                end
                if (st_r.mode == MODE_CLEAR_ON_MATCH) begin
                    st_nxt.cnt = RST_WORD;
                    if (st_r.cc_first == CNT_MAX) begin
                        st_nxt.ovf = 1'b1;
                    end
                end
            end
            if (match_second) begin
                st_nxt.irq_second = 1'b1;
                if (st_r.toc[TOC_TOGGLE_SECOND]) begin
                    st_nxt.lvl = ~st_nxt.lvl;
                end
            end
            if (cap_second) begin
                st_nxt.cc_second = st_r.cnt;
                st_nxt.irq_second = 1'b1;
            end
            if (a_valid && st_r.mode == MODE_CLEAR_ON_EDGE) begin
                st_nxt.cnt = RST_WORD;
            end
            if (cap_first) begin
                // a capture overrides a same-cycle write; a read in flight returns the value latched before the capture
                st_nxt.cc_first = st_r.cnt;
                st_nxt.irq_first = ~st_r.crc[CRC_FIRST_REVERSE_A];
            end
        end
        st_nxt.pin = st_r.toc[TOC_PIN_EN] & st_nxt.lvl;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.mode <= MODE_STOP;
            st_r.crc <= RST_CRC;
            st_r.toc <= RST_TOC;
            st_r.prm <= RST_PRM;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign timer_output_pin_o = st_r.pin;
    assign first_match_capture_irq_o = st_r.irq_first;
    assign second_match_capture_irq_o = st_r.irq_second;

    // ==========================================
    // assertions
    property p_cap_first;
        @(posedge clk_i) disable iff (rst_i) (ce_i && cap_first) |=> (st_r.cc_first == $past(st_r.cnt));
    endproperty
    a_cap_first: assert property (p_cap_first) else $error("first capture missed");

    property p_cap_second;
        @(posedge clk_i) disable iff (rst_i) (ce_i && cap_second) |=> (st_r.cc_second == $past(st_r.cnt)) && second_match_capture_irq_o;
    endproperty
    a_cap_second: assert property (p_cap_second) else $error("second capture missed");

    property p_rev_no_irq;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && run && st_r.crc[CRC_FIRST_CAPTURE] && st_r.crc[CRC_FIRST_REVERSE_A]) |=> !first_match_capture_irq_o;
    endproperty
    a_rev_no_irq: assert property (p_rev_no_irq) else $error("irq on reverse capture");

    property p_no_toggle_second;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && match_second && !match_first && !st_r.toc[TOC_TOGGLE_SECOND]) |=> $stable(st_r.lvl);
    endproperty
    a_no_toggle_second: assert property (p_no_toggle_second) else $error("untimely toggle");

    property p_level_high;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !run && st_r.toc[TOC_LEVEL_SET] && !st_r.toc[TOC_LEVEL_RESET]) |=> st_r.lvl;
    endproperty
    a_level_high: assert property (p_level_high) else $error("level set failed");

    property p_level_hold;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !run && !st_r.toc[TOC_LEVEL_SET] && !st_r.toc[TOC_LEVEL_RESET]) |=> $stable(st_r.lvl);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level not held");

    property p_toggle_first;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && match_first && !match_second && st_r.toc[TOC_TOGGLE_FIRST]) |=> (st_r.lvl != $past(st_r.lvl));
    endproperty
    a_toggle_first: assert property (p_toggle_first) else $error("first toggle missed");

    property p_ovf_match;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && match_first && st_r.mode == MODE_CLEAR_ON_MATCH && st_r.cc_first == CNT_MAX) |=> st_r.ovf && st_r.cnt == 16'h0000;
    endproperty
    a_ovf_match: assert property (p_ovf_match) else $error("overflow on clear missed");

    property p_edge_clear;
        @(posedge clk_i) disable iff (rst_i) (ce_i && a_valid && st_r.mode == MODE_CLEAR_ON_EDGE) |=> st_r.cnt == 16'h0000;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge clear missed");

    property p_count;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && run && tick && !match_first && !a_valid) |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("count step wrong");

endmodule

//--- pulse_source.sv
// partner model: the external pulse sources on the two trigger pins
// assumes the bench calls its task from the clk_i domain, one pulse at a time
`timescale 1ns/100ps

module pulse_source (
    // clock
    input wire logic clk_i,
    // trigger pins
    output logic trigger_input_a_o,
    output logic trigger_input_b_o
);
    // ==========================================
    // idle level
    initial begin
        trigger_input_a_o = 1'b0;
        trigger_input_b_o = 1'b0;
    end

    // ==========================================
    // one pulse on a or b, hi cycles high then lo cycles low
    task automatic pulse(input bit on_b, input int hi, input int lo);
        @(posedge clk_i);
        {trigger_input_b_o, trigger_input_a_o} <= on_b ? 2'b10 : 2'b01;
        repeat (hi) @(posedge clk_i);
        {trigger_input_b_o, trigger_input_a_o} <= 2'b00;
        repeat (lo) @(posedge clk_i); // next pulse only after this one ends
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the 16-bit capture/compare timer
// assumes the design package and pulse_source are compiled first
`timescale 1ns/100ps

module tb_top;
    import capture_compare_timer16_pkg::*;

    // ==========================================
    // clock, reset, signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    wb_req_s req = '0;
    logic ack;
    logic [31:0] rd_dat;
    logic [31:0] rdat;
    logic pin;
    logic irq1;
    logic irq2;
    logic trig_a;
    logic trig_b;
    int mismatches = 0;
    int n_tests = 0;
    int cyc_n = 0;
    int n_irq1 = 0;
    int n_irq2 = 0;
    int t_irq1 = 0;
    int t_irq2 = 0;
    int t_ack = 0;

    always #2.5 clk_i = ~clk_i;

    capture_compare_timer16 uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rd_dat),
        .trigger_input_a_i(trig_a), .trigger_input_b_i(trig_b), .timer_output_pin_o(pin),
        .first_match_capture_irq_o(irq1), .second_match_capture_irq_o(irq2)
    );

    pulse_source src (.clk_i(clk_i), .trigger_input_a_o(trig_a), .trigger_input_b_o(trig_b));

    // ==========================================
    // cycle and event counters
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (irq1 === 1'b1) begin
            n_irq1 <= n_irq1 + 1;
            t_irq1 <= cyc_n;
        end
        if (irq2 === 1'b1) begin
            n_irq2 <= n_irq2 + 1;
            t_irq2 <= cyc_n;
        end
    end

    // ==========================================
    // report and checks
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        mismatches++;
        $display("mismatch %s expected answer seen none", what);
        close_out();
    endtask

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g, input int tol = 0);
        logic [31:0] d;
        d = (g > e) ? g - e : e - g;
        n_tests++;
        if ($isunknown(g) || d > tol) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic pin_is(input string what, input logic e);
        repeat (3) @(posedge clk_i);
        check(what, {31'h0, e}, {31'h0, pin});
    endtask

    // ==========================================
    // classic wishbone single cycle
    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wdat);
        int i;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wdat};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (i == 20) give_up("bus ack");
        rdat = rd_dat;
        t_ack = cyc_n;
        req <= '0;
    endtask

    task automatic wait_irq(input bit second, input int limit);
        int start;
        int i;
        start = second ? n_irq2 : n_irq1;
        for (i = 0; i < limit; i++) begin
            @(posedge clk_i);
            if ((second ? n_irq2 : n_irq1) != start) break;
        end
        if (i == limit) give_up("event pulse");
    endtask

    // ==========================================
    // main sequence
    initial begin
        logic p;
        int c1;
        int c2;
        int t0;
        logic [31:0] v;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            wb(1'b0, 5'(a * 4), 32'h0);
            check("reset word", 32'h0, rdat);
        end
        // level control while stopped
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h09);
        pin_is("pin set", 1'b1);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h05);
        pin_is("pin reset", 1'b0);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h09);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h03);
        pin_is("pin held", 1'b1);
        // toggle on first match, clear on match
        wb(1'b1, OFS_CC_FIRST, 32'h40);
        wb(1'b1, OFS_MODE_CONTROL, 32'h0c);
        check("pin at start", 32'h1, {31'h0, pin});
        wait_irq(1'b0, 200);
        t0 = t_irq1;
        pin_is("pin first toggle", 1'b0);
        wait_irq(1'b0, 200);
        check("match period", 32'h41, 32'(t_irq1 - t0), 1);
        pin_is("pin again", 1'b1);
        // toggle on second match and safe rewrite
        wb(1'b1, OFS_MODE_CONTROL, 32'h00);
        wb(1'b1, OFS_CC_SECOND, 32'h10);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h11);
        wb(1'b1, OFS_MODE_CONTROL, 32'h0c);
        p = pin;
        wait_irq(1'b1, 200);
        pin_is("pin second match", !p);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h01);
        wb(1'b1, OFS_CC_SECOND, 32'h08);
        @(posedge clk_i);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h11);
        p = pin;
        wait_irq(1'b1, 200);
        check("second after first", 32'h9, 32'(t_irq2 - t_irq1), 1);
        pin_is("pin new second", !p);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h01);
        p = pin;
        wait_irq(1'b1, 200);
        pin_is("pin toggle off", p);
        // pulse width capture, clear on a edge
        wb(1'b1, OFS_MODE_CONTROL, 32'h00);
        wb(1'b1, OFS_OUTPUT_CONTROL, 32'h00);
        wb(1'b1, OFS_PRESCALER_MODE, 32'h50);
        wb(1'b1, OFS_CAPTURE_COMPARE_CONTROL, 32'h07);
        wb(1'b1, OFS_MODE_CONTROL, 32'h08);
        c1 = n_irq1;
        c2 = n_irq2;
        src.pulse(1'b0, 40, 60);
        src.pulse(1'b0, 40, 60);
        wb(1'b0, OFS_CC_SECOND, 32'h0);
        check("cycle capture", 32'd101, rdat, 1);
        wb(1'b0, OFS_CC_FIRST, 32'h0);
        check("high capture", 32'd40, rdat, 1);
        check("reverse edge irq", 32'(c1), 32'(n_irq1));
        check("a capture irqs", 32'(c2 + 2), 32'(n_irq2));
        // free run capture on a and b
        wb(1'b1, OFS_MODE_CONTROL, 32'h00);
        wb(1'b1, OFS_PRESCALER_MODE, 32'hf0);
        wb(1'b1, OFS_CAPTURE_COMPARE_CONTROL, 32'h05);
        wb(1'b1, OFS_MODE_CONTROL, 32'h04);
        c1 = n_irq1;
        src.pulse(1'b0, 20, 30);
        src.pulse(1'b1, 20, 30);
        wb(1'b0, OFS_CC_FIRST, 32'h0);
        v = rdat;
        wb(1'b0, OFS_CC_SECOND, 32'h0);
        check("a to b distance", 32'd51, v - rdat, 1);
        check("b capture irq", 32'(c1 + 2), 32'(n_irq1));
        wb(1'b0, OFS_COUNTER, 32'h0);
        v = rdat;
        t0 = t_ack;
        wb(1'b0, OFS_COUNTER, 32'h0);
        check("count rate", 32'(t_ack - t0), rdat - v);
        // clock enable freezes the counter
        ce <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce <= 1'b1;
        v = rdat;
        t0 = t_ack;
        wb(1'b0, OFS_COUNTER, 32'h0);
        check("count frozen", 32'(t_ack - t0 - 10), rdat - v);
        // slow count clock, one tick in eight
        wb(1'b1, OFS_MODE_CONTROL, 32'h00);
        wb(1'b1, OFS_PRESCALER_MODE, 32'h03);
        wb(1'b1, OFS_MODE_CONTROL, 32'h04);
        wb(1'b0, OFS_COUNTER, 32'h0);
        v = rdat;
        t0 = t_ack;
        repeat (80) @(posedge clk_i);
        wb(1'b0, OFS_COUNTER, 32'h0);
        check("slow count", 32'((t_ack - t0) / 8), rdat - v, 1);
        // overflow on clear from ffff
        wb(1'b1, OFS_MODE_CONTROL, 32'h00);
        wb(1'b1, OFS_PRESCALER_MODE, 32'h00);
        wb(1'b1, OFS_CAPTURE_COMPARE_CONTROL, 32'h00);
        wb(1'b1, OFS_CC_FIRST, 32'hffff);
        wb(1'b1, OFS_MODE_CONTROL, 32'h0c);
        wait_irq(1'b0, 70000);
        wb(1'b0, OFS_MODE_CONTROL, 32'h0);
        check("overflow on clear", 32'h0d, rdat);
        wb(1'b1, OFS_MODE_CONTROL, 32'h0c);
        wb(1'b0, OFS_MODE_CONTROL, 32'h0);
        check("overflow cleared", 32'h0c, rdat);
        close_out();
    end
endmodule
